// file: verilog/srcd_core.v
// Purpose: Command interpreter and diagnostic engine of a serial radio module.
// Assumes: Bytes arrive from a UART receiver; the radio takes bits and bytes.
// Notes: Diagnostic operation is left only through rst_n.
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "srcd_defines.vh"

// How it works
// - Low command select means command mode.
// - Command-mode bytes are commands, never radio payload.
// - Select low at power-up restores factory settings.
// - Diagnostics stay active until reset.
// - Mode and power apply only at diagnostics.
// - Receive diagnostic ignores the power selection.
// - Transmit diagnostic sends alternating bits continuously.
// - Channel is low, mid, high or explicit.
// - Receive diagnostic runs a bit error test.
// - Report error count and percentage to host.
// - Error test may wait forever for pattern.
// - Serial rate above 38400 baud only when power-up loads a code above 4 from storage.
// - Factory serial rate is 2400 baud.
// - Power-up loads settings from storage.
// - Volatile settings apply at once.
module srcd_core #(
    parameter BIT_DIV_BASE = (`SRCD_CLK_HZ / `SRCD_BASE_BAUD)
)
(
    input wire sys_clk,
    input wire rst_n,
    input wire cmd_n,
    input wire [7:0] rx_byte,
    input wire rx_valid,
    output reg [7:0] host_tx_byte,
    output wire host_tx_valid,
    input wire host_tx_ready,
    output reg [2:0] baud_sel,
    output reg [7:0] rf_tx_byte,
    output reg rf_tx_valid,
    output reg rf_tx_on,
    output reg rf_tx_bit,
    output reg rf_rx_on,
    input wire rf_rx_bit,
    input wire rf_rx_bit_valid,
    output reg rf_mode,
    output reg [1:0] rf_power,
    output reg [7:0] rf_channel,
    input wire [15:0] nv_rd_data,
    output reg [15:0] nv_wr_data,
    output reg nv_wr,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_we,
    input wire reg_re,
    output reg [15:0] reg_rdata
);

localparam D_NONE = 2'h0;
localparam D_TX = 2'h1;
localparam D_RX = 2'h2;
localparam B_HUNT = 2'h0;
localparam B_COUNT = 2'h1;
localparam B_REPORT = 2'h2;
localparam B_DONE = 2'h3;

reg booted;
reg [15:0] settings;
reg [1:0] diag;
reg [1:0] ber_state;
reg pend_chnum;
reg [14:0] bit_cnt;
reg [3:0] run;
reg last_bit;
reg expect_bit;
reg [9:0] bits_seen;
reg [9:0] err_cnt;
reg [1:0] rep_idx;
reg [15:0] next_settings;
reg start_tx;
reg start_rx;
reg save_nv;
reg [7:0] sel_channel;
wire cmd_mode;
wire [14:0] bit_div;
wire bit_tick;
wire [9:0] err_pct;

assign cmd_mode = ~cmd_n;
assign bit_div = BIT_DIV_BASE[14:0] >> settings[`SRCD_F_BAUD];
assign bit_tick = (bit_cnt == 15'h0000);
assign err_pct = err_cnt[9:0] / 10'h00A;
assign host_tx_valid = (ber_state == B_REPORT) && (diag == D_RX);

// ==========================================================================
// Channel resolution
// ==========================================================================
always @*
begin
    case (settings[`SRCD_F_CHSEL])
        `SRCD_CHSEL_LOW: sel_channel = `SRCD_CH_LOW;
        `SRCD_CHSEL_MID: sel_channel = `SRCD_CH_MID;
        `SRCD_CHSEL_HIGH: sel_channel = `SRCD_CH_HIGH;
        default: sel_channel = settings[`SRCD_F_CHNUM];
    endcase
end

// ==========================================================================
// Command decode from bus and serial
// ==========================================================================
always @*
begin
    next_settings = settings;
    start_tx = 1'b0;
    start_rx = 1'b0;
    save_nv = 1'b0;
    if (rx_valid && cmd_mode && booted && !pend_chnum)
    begin
        case (rx_byte[7:4])
            `SRCD_OP_CHSEL: next_settings[`SRCD_F_CHSEL] = rx_byte[1:0];
            `SRCD_OP_MODE: next_settings[`SRCD_F_MODE] = rx_byte[0];
            `SRCD_OP_POWER: next_settings[`SRCD_F_POWER] = rx_byte[1:0];
            `SRCD_OP_BAUD:
            begin
                if (rx_byte[2:0] <= `SRCD_BAUD_MAX)
                    next_settings[`SRCD_F_BAUD] = rx_byte[2:0];
            end
            `SRCD_OP_TX_DIAG: start_tx = 1'b1;
            `SRCD_OP_RX_DIAG: start_rx = 1'b1;
            `SRCD_OP_NV_SAVE: save_nv = 1'b1;
            default: next_settings = settings;
        endcase
    end
    else if (rx_valid && cmd_mode && booted)
    begin
        next_settings[`SRCD_F_CHNUM] = rx_byte;
    end
    if (reg_we && booted)
    begin
        case (reg_addr)
            `SRCD_REG_SET:
            begin
                next_settings = reg_wdata;
                if (reg_wdata[`SRCD_F_BAUD] > `SRCD_BAUD_MAX)
                    next_settings[`SRCD_F_BAUD] = settings[`SRCD_F_BAUD];
            end
            `SRCD_REG_DIAG:
            begin
                start_tx = reg_wdata[0];
                start_rx = reg_wdata[1] & ~reg_wdata[0];
            end
            `SRCD_REG_NV_SAVE: save_nv = 1'b1;
            default: save_nv = 1'b0;
        endcase
    end
end

// ==========================================================================
// Settings, boot load and storage writes
// ==========================================================================
always @(posedge sys_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        booted <= 1'b0;
        settings <= `SRCD_FACTORY;
        baud_sel <= 3'h0;
        pend_chnum <= 1'b0;
        nv_wr <= 1'b0;
        nv_wr_data <= 16'h0000;
    end
    else if (!booted)
    begin
        booted <= 1'b1;
        if (cmd_mode)
        begin
            settings <= `SRCD_FACTORY;
            baud_sel <= 3'h0;
            nv_wr <= 1'b1;
            nv_wr_data <= `SRCD_FACTORY;
        end
        else
        begin
            settings <= nv_rd_data;
            baud_sel <= nv_rd_data[`SRCD_F_BAUD];
        end
    end
    else
    begin
        settings <= next_settings;
        baud_sel <= next_settings[`SRCD_F_BAUD];
        nv_wr <= save_nv;
        if (save_nv)
            nv_wr_data <= settings;
        if (rx_valid && cmd_mode)
            pend_chnum <= !pend_chnum && (rx_byte[7:4] == `SRCD_OP_CHNUM);
    end
end

// ==========================================================================
// Payload forwarding to the radio
// ==========================================================================
always @(posedge sys_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        rf_tx_byte <= 8'h00;
        rf_tx_valid <= 1'b0;
    end
    else
    begin
        rf_tx_valid <= rx_valid && !cmd_mode && booted && (diag == D_NONE);
        if (rx_valid && !cmd_mode && (diag == D_NONE))
            rf_tx_byte <= rx_byte;
    end
end

// ==========================================================================
// Diagnostic entry, transmit pattern and bit clock
// ==========================================================================
always @(posedge sys_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        diag <= D_NONE;
        rf_tx_on <= 1'b0;
        rf_rx_on <= 1'b0;
        rf_mode <= 1'b0;
        rf_power <= 2'h0;
        rf_channel <= 8'h00;
        rf_tx_bit <= 1'b0;
        bit_cnt <= 15'h0000;
    end
    else
    begin
        bit_cnt <= bit_tick ? bit_div - 15'h0001 : bit_cnt - 15'h0001;
        if (diag == D_NONE && start_tx)
        begin
            diag <= D_TX;
            rf_tx_on <= 1'b1;
            rf_mode <= settings[`SRCD_F_MODE];
            rf_power <= settings[`SRCD_F_POWER];
            rf_channel <= sel_channel;
        end
        else if (diag == D_NONE && start_rx)
        begin
            diag <= D_RX;
            rf_rx_on <= 1'b1;
            rf_mode <= settings[`SRCD_F_MODE];
            rf_channel <= sel_channel;
        end
        if (diag == D_TX && bit_tick)
            rf_tx_bit <= ~rf_tx_bit;
    end
end

// ==========================================================================
// Receive bit error test and report
// ==========================================================================
always @(posedge sys_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        ber_state <= B_HUNT;
        run <= 4'h0;
        last_bit <= 1'b0;
        expect_bit <= 1'b0;
        bits_seen <= 10'h000;
        err_cnt <= 10'h000;
        rep_idx <= 2'h0;
        host_tx_byte <= 8'h00;
    end
    else if (diag == D_RX)
    begin
        case (ber_state)
            B_HUNT:
            begin
                if (rf_rx_bit_valid)
                begin
                    last_bit <= rf_rx_bit;
                    expect_bit <= ~rf_rx_bit;
                    if (run != 4'h0 && rf_rx_bit == last_bit)
                        run <= 4'h1;
                    else if (run == `SRCD_HUNT_LEN - 4'h1)
                        ber_state <= B_COUNT;
                    else
                        run <= run + 4'h1;
                end
            end
            B_COUNT:
            begin
                if (rf_rx_bit_valid)
                begin
                    expect_bit <= ~expect_bit;
                    bits_seen <= bits_seen + 10'h001;
                    if (rf_rx_bit != expect_bit)
                        err_cnt <= err_cnt + 10'h001;
                    if (bits_seen == `SRCD_BER_BITS - 10'h001)
                    begin
                        ber_state <= B_REPORT;
                        host_tx_byte <= {6'h00, err_cnt[9:8]};
                    end
                end
            end
            B_REPORT:
            begin
                if (host_tx_ready)
                begin
                    rep_idx <= rep_idx + 2'h1;
                    case (rep_idx)
                        2'h0: host_tx_byte <= err_cnt[7:0];
                        2'h1: host_tx_byte <= {1'b0, err_pct[6:0]};
                        default: ber_state <= B_DONE;
                    endcase
                end
            end
            default: ber_state <= B_DONE;
        endcase
    end
end

// ==========================================================================
// Register read port
// ==========================================================================
always @(posedge sys_clk or negedge rst_n)
begin
    if (!rst_n)
        reg_rdata <= 16'h0000;
    else if (reg_re)
    begin
        case (reg_addr)
            `SRCD_REG_SET: reg_rdata <= settings;
            `SRCD_REG_STATUS: reg_rdata <= {10'h000, ber_state, diag, booted, cmd_mode};
            `SRCD_REG_BER_ERR: reg_rdata <= {6'h00, err_cnt};
            `SRCD_REG_BER_PCT: reg_rdata <= {6'h00, err_pct};
            default: reg_rdata <= 16'h0000;
        endcase
    end
    else
        reg_rdata <= 16'h0000;
end

endmodule // srcd_core

// file: inc/srcd_defines.vh
// Purpose: Constants of the serial radio command and diagnostic core.
// Assumes: Included by the core and the bench.
// Notes: Settings word layout is shared by the bus, the serial commands and storage.
`ifndef SRCD_DEFINES_VH
`define SRCD_DEFINES_VH
// ==========================================================================
// Register offsets (word index on the plain register port)
// ==========================================================================
`define SRCD_REG_SET 4'h0
`define SRCD_REG_DIAG 4'h1
`define SRCD_REG_STATUS 4'h2
`define SRCD_REG_BER_ERR 4'h3
`define SRCD_REG_BER_PCT 4'h4
`define SRCD_REG_NV_SAVE 4'h5
// ==========================================================================
// Settings word fields
// ==========================================================================
`define SRCD_F_BAUD 2:0
`define SRCD_F_MODE 3
`define SRCD_F_POWER 5:4
`define SRCD_F_CHSEL 7:6
`define SRCD_F_CHNUM 15:8
`define SRCD_FACTORY 16'h0000
// ==========================================================================
// Baud codes, channel presets and diagnostic bit pattern figures
// ==========================================================================
`define SRCD_BAUD_MAX 3'h4
`define SRCD_CHSEL_LOW 2'h0
`define SRCD_CHSEL_MID 2'h1
`define SRCD_CHSEL_HIGH 2'h2
`define SRCD_CH_LOW 8'h00
`define SRCD_CH_MID 8'h20
`define SRCD_CH_HIGH 8'h3F
`define SRCD_HUNT_LEN 4'h8
`define SRCD_BER_BITS 10'h3E8
`define SRCD_CLK_HZ 40000000
`define SRCD_BASE_BAUD 2400
// ==========================================================================
// Serial command opcodes (upper nibble of a command byte)
// ==========================================================================
`define SRCD_OP_CHSEL 4'h1
`define SRCD_OP_MODE 4'h2
`define SRCD_OP_POWER 4'h3
`define SRCD_OP_BAUD 4'h4
`define SRCD_OP_TX_DIAG 4'h5
`define SRCD_OP_RX_DIAG 4'h6
`define SRCD_OP_NV_SAVE 4'h7
`define SRCD_OP_CHNUM 4'h8
`endif

// file: test/srcd_core_sva.sv
// Purpose: Assertions on the ports of the command core.
// Assumes: One clock domain.
// Notes: Bound to every srcd_core.
`timescale 1ns/1ps
module srcd_chk (
    input wire sys_clk,
    input wire rst_n,
    input wire cmd_n,
    input wire [7:0] rx_byte,
    input wire rx_valid,
    input wire [7:0] rf_tx_byte,
    input wire rf_tx_valid,
    input wire rf_tx_on,
    input wire rf_tx_bit,
    input wire rf_rx_on,
    input wire rf_mode,
    input wire [1:0] rf_power,
    input wire [7:0] rf_channel,
    input wire nv_wr,
    input wire [2:0] baud_sel
);
    reg up;
    reg pend_ch;
    // A byte after the explicit channel opcode is a channel number, not a command.
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            up <= 1'b0;
            pend_ch <= 1'b0;
        end
        else
        begin
            up <= 1'b1;
            if (up && rx_valid && !cmd_n)
                pend_ch <= !pend_ch && (rx_byte[7:4] == 4'h8);
        end
    end
    // ==========
    // Assertions
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_cmd;
        rx_valid && !cmd_n && $past(rst_n);
    endsequence
    sequence s_pay;
        rx_valid && cmd_n && !rf_tx_on && !rf_rx_on && $past(rst_n);
    endsequence
    chk_cmd_swallow: assert property (s_cmd |=> !rf_tx_valid)
        else $error("byte forwarded in command mode");
    chk_payload_fwd: assert property (s_pay |=> rf_tx_valid && rf_tx_byte == $past(rx_byte))
        else $error("payload byte lost");
    chk_tx_entry: assert property (s_cmd ##0 (rx_byte[7:4] == 4'h5 && !rf_rx_on && !pend_ch) |=> rf_tx_on)
        else $error("transmit test not started");
    chk_diag_stays: assert property ((rf_tx_on || rf_rx_on) |=> $stable({rf_tx_on, rf_rx_on}))
        else $error("diagnostic left without reset");
    chk_apply_entry: assert property (!($rose(rf_tx_on) || $rose(rf_rx_on)) |-> $stable({rf_mode, rf_channel}))
        else $error("radio setting changed outside entry");
    chk_power_hold: assert property (!$rose(rf_tx_on) |-> $stable(rf_power))
        else $error("power changed outside transmit entry");
    chk_pattern_runs: assert property (rf_tx_on |-> ##[1:20] $changed(rf_tx_bit))
        else $error("test pattern stalled");
    chk_baud_limit: assert property (baud_sel <= 3'h4)
        else $error("serial rate code too high");
    chk_factory_save: assert property ($rose(rst_n) ##0 !cmd_n |=> ##[0:1] nv_wr)
        else $error("factory settings not stored");
endmodule // srcd_chk

bind srcd_core srcd_chk u_chk (.*);

// file: test/srcd_host.sv
// Purpose: Host terminal that takes report bytes.
// Assumes: Ready one cycle in four when slow.
// Notes: Bytes are kept in rxq.
`timescale 1ns/1ps
module srcd_host (
    input wire sys_clk,
    input wire rst_n,
    input wire slow,
    input wire [7:0] host_tx_byte,
    input wire host_tx_valid,
    output reg host_tx_ready
);
    reg [1:0] cnt;
    reg [7:0] rxq[$];
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= 2'h0;
            host_tx_ready <= 1'b0;
        end
        else
        begin
            cnt <= cnt + 2'h1;
            host_tx_ready <= !slow || cnt == 2'h2;
            if (host_tx_valid && host_tx_ready)
                rxq.push_back(host_tx_byte);
        end
    end
endmodule // srcd_host

// file: test/tb.sv
// Purpose: Self-checking bench of the command core.
// Assumes: Bit period shortened to 16 cycles.
// Notes: Payload expectations live in a queue.
`timescale 1ns/1ps
`include "srcd_defines.vh"
`define CMP(n, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
    reg sys_clk = 1'b0;
    reg rst_n = 1'b0;
    reg cmd_n = 1'b1;
    reg [7:0] rx_byte = 8'h00;
    reg rx_valid = 1'b0;
    reg rf_rx_bit = 1'b0;
    reg rf_rx_bit_valid = 1'b0;
    reg [15:0] nv_rd_data = 16'h0000;
    reg [3:0] reg_addr = 4'h0;
    reg [15:0] reg_wdata = 16'h0000;
    reg reg_we = 1'b0;
    reg reg_re = 1'b0;
    reg slow = 1'b0;
    wire [7:0] host_tx_byte, rf_tx_byte, rf_channel;
    wire host_tx_valid, host_tx_ready, rf_tx_valid, rf_tx_on, rf_tx_bit, rf_rx_on, rf_mode, nv_wr;
    wire [2:0] baud_sel;
    wire [1:0] rf_power;
    wire [15:0] nv_wr_data, reg_rdata;
    integer seed = 77603;
    integer miscompares = 0;
    integer n_compared = 0;
    integer cyc = 0;
    integer nvn = 0;
    integer dg = 0;
    integer k, i, e, t;
    reg [15:0] nvd, d, s;
    reg [7:0] ch, x;
    reg [7:0] pq[$];
    always #12.5 sys_clk = ~sys_clk;
    srcd_core #(.BIT_DIV_BASE(16)) u_srcd_core (.*);
    srcd_host u_srcd_host (.*);
    // ==========
    // Monitors and bus tasks
    always @(posedge sys_clk)
    begin
        cyc++;
        if (nv_wr)
        begin
            nvn++;
            nvd = nv_wr_data;
        end
        if (rst_n && rf_tx_valid)
        begin
            x = pq.size() ? pq.pop_front() : 8'hXX;
            `CMP("rf_tx_byte", x, rf_tx_byte)
        end
        if (cyc == 20000)
        begin
            miscompares++;
            results;
        end
    end
    task wr(input [3:0] a, input [15:0] v);
    begin
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_we <= 1'b1;
        @(posedge sys_clk);
        reg_we <= 1'b0;
        #1;
    end
    endtask
    task rd(input [3:0] a);
    begin
        @(posedge sys_clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge sys_clk);
        reg_re <= 1'b0;
        #1 d = reg_rdata;
    end
    endtask
    task sb(input [7:0] b);
    begin
        @(posedge sys_clk);
        rx_byte <= b;
        rx_valid <= 1'b1;
        if (cmd_n && dg == 0)
            pq.push_back(b);
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        #1;
    end
    endtask
    task bit1(input v);
    begin
        @(posedge sys_clk);
        rf_rx_bit <= v;
        rf_rx_bit_valid <= 1'b1;
        @(posedge sys_clk);
        rf_rx_bit_valid <= 1'b0;
    end
    endtask
    task boot(input c, input [15:0] nv);
    begin
        @(posedge sys_clk);
        rst_n <= 1'b0;
        cmd_n <= c;
        nv_rd_data <= nv;
        dg = 0;
        pq.delete();
        u_srcd_host.rxq.delete();
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        nvn = 0;
        repeat (3) @(posedge sys_clk);
        #1;
    end
    endtask
    task results;
    begin
        if (miscompares == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask
    // ==========
    // Scenarios
    initial
    begin
        s = 16'($random(seed));
        s[2:0] = s[2:0] % 3'h5;
        boot(1'b1, s);
        `CMP("baud_sel", s[2:0], baud_sel)
        rd(`SRCD_REG_SET);
        `CMP("set", s, d)
        rd(`SRCD_REG_STATUS);
        `CMP("status", 16'h0002, d)
        repeat (6) sb(8'($random(seed)));
        @(posedge sys_clk) cmd_n <= 1'b0;
        rd(`SRCD_REG_STATUS);
        `CMP("status", 16'h0003, d)
        sb(8'h47);
        `CMP("baud_sel", s[2:0], baud_sel)
        sb(8'h44);
        `CMP("baud_sel", 3'h4, baud_sel)
        wr(`SRCD_REG_SET, 16'hA5FF);
        `CMP("baud_sel", 3'h4, baud_sel)
        rd(`SRCD_REG_SET);
        `CMP("set", 16'hA5FC, d)
        wr(4'hE, 16'hFFFF);
        wr(`SRCD_REG_NV_SAVE, 16'h0001);
        rd(4'hE);
        `CMP("unmapped", 16'h0000, d)
        `CMP("nv_wr_data", 16'hA5FC, nvd)
        `CMP("rf_power", 2'h0, rf_power)
        for (k = 0; k < 4; k++)
        begin
            boot(1'b1, 16'h0000);
            @(posedge sys_clk) cmd_n <= 1'b0;
            ch = 8'($random(seed));
            e = $random(seed);
            sb({6'h04, k[1:0]});
            sb(8'h80);
            sb(ch);
            sb({7'h10, e[0]});
            sb({6'h0C, e[2:1]});
            `CMP("rf_mode", 1'b0, rf_mode)
            if (k == 1)
                wr(`SRCD_REG_DIAG, 16'h0002);
            else if (k == 2)
                wr(`SRCD_REG_DIAG, 16'h0001);
            else
                sb(k[0] ? 8'h61 : 8'h50);
            dg = 1;
            `CMP("rf_channel", k == 0 ? 8'h00 : k == 1 ? 8'h20 : k == 2 ? 8'h3F : ch, rf_channel)
            `CMP("rf_mode", e[0], rf_mode)
            `CMP("rf_power", k[0] ? 2'h0 : e[2:1], rf_power)
            wr(`SRCD_REG_DIAG, 16'h0003);
            @(posedge sys_clk) cmd_n <= 1'b1;
            sb(8'($random(seed)));
            `CMP("diag", ({!k[0], k[0]}), ({rf_tx_on, rf_rx_on}))
            t = 0;
            if (!k[0])
                repeat (64)
                begin
                    x[0] = rf_tx_bit;
                    @(posedge sys_clk);
                    #1 t = t + (rf_tx_bit !== x[0]);
                end
            else
            begin
                slow = (k == 1);
                repeat (20) bit1(1'b0);
                rd(`SRCD_REG_STATUS);
                `CMP("ber_state", 2'h0, d[5:4])
                e = $random(seed) & 31;
                for (i = -8; i < 1004; i++)
                    bit1(i[0] ^ (i > 0 && i % 20 == 0 && i / 20 <= e));
                while (u_srcd_host.rxq.size() < 3 && t < 500)
                begin
                    @(posedge sys_clk);
                    t++;
                end
                `CMP("ber_hi", 8'h00, u_srcd_host.rxq[0])
                `CMP("ber_lo", e[7:0], u_srcd_host.rxq[1])
                `CMP("ber_pct", e[7:0] / 8'h0A, u_srcd_host.rxq[2])
                rd(`SRCD_REG_STATUS);
                `CMP("status", 16'h003A, d)
                rd(`SRCD_REG_BER_ERR);
                `CMP("ber_err", e[15:0], d)
                rd(`SRCD_REG_BER_PCT);
                `CMP("ber_pct_reg", e[15:0] / 16'h000A, d)
                t = 4;
            end
            `CMP("toggles", 4, t)
        end
        boot(1'b0, 16'hFFFC);
        `CMP("nv_wr_n", 1, nvn)
        `CMP("nv_wr_data", 16'h0000, nvd)
        `CMP("baud_sel", 3'h0, baud_sel)
        rd(`SRCD_REG_SET);
        `CMP("set", 16'h0000, d)
        sb(8'h43);
        sb(8'h70);
        `CMP("baud_sel", 3'h3, baud_sel)
        rd(`SRCD_REG_SET);
        `CMP("set", 16'h0003, d)
        `CMP("nv_wr_n", 2, nvn)
        `CMP("nv_wr_data", 16'h0003, nvd)
        results;
    end
endmodule // tb
